// ### rtl/mac_rx_address_filter_descq.sv
module mac_rx_address_filter_descq (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic rx_clk,
   input wire logic [3:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic tx_active,
   output logic jam_tx_en,
   output logic [3:0] jam_txd,
   output logic [31:0] dma_address,
   output logic dma_read,
   output logic dma_write,
   output logic [31:0] dma_writedata,
   input wire logic [31:0] dma_readdata,
   input wire logic dma_waitrequest,
   output logic store_frame,
   output logic local_match
);

   // Merge a write into a register under byte enables
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      integer i;
      r = old;
      for (i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // Reflected CRC-32 over one byte, LSB first as on the wire
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      integer i;
      r = c;
      for (i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ mac_rx_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   logic [31:0] ctl;
   logic [31:0] cfg;
   logic [31:0] rbqp;
   logic [31:0] hash_hi;
   logic [31:0] hash_lo;
   logic [31:0] sa_lo [4];
   logic [15:0] sa_hi [4];
   logic [3:0] sa_act;
   logic rsr_bna;
   logic [9:0] qcnt;
   mac_rx_pkg::desc_state_e state;
   logic [31:0] w0;
   logic [2:0] rxc_s;
   logic [3:0] rxd_s1;
   logic [3:0] rxd_s2;
   logic dv_s1;
   logic dv_s2;
   logic er_s1;
   logic er_s2;
   logic dv_d;
   logic in_frame;
   logic nib_hi;
   logic [3:0] low_nib;
   logic [10:0] byte_cnt;
   logic err_seen;
   logic [47:0] da;
   logic [31:0] crc;
   logic da_done;
   logic stored;
   logic bc_f;
   logic mh_f;
   logic uh_f;
   logic [3:0] sa_f;
   logic [4:0] jam_cnt;

   // Bus decode; each register is one aligned word
   wire req = read | write;
   wire wr_fire = write & ~waitrequest;
   wire [7:0] sa_rel = address - mac_rx_pkg::OFS_SA_BASE;
   wire sa_hit = (address >= mac_rx_pkg::OFS_SA_BASE) && (address <= mac_rx_pkg::OFS_SA_LAST)
                 && (address[1:0] == 2'h0);
   wire [1:0] sa_idx = sa_rel[4:3];
   wire sa_hi_sel = sa_rel[2];
   wire [31:0] qptr = rbqp | {19'h0, qcnt, 3'h0}; // Counter ORed into base
   wire [31:0] rsr_word = 32'(rsr_bna) << mac_rx_pkg::RSR_BNA;
   wire [31:0] sa_word = sa_hi_sel ? {16'h0, sa_hi[sa_idx]} : sa_lo[sa_idx];
   wire [31:0] sa_hi_new = be_merge({16'h0, sa_hi[sa_idx]}, writedata, byteenable);
   wire [31:0] rd_mux =
      (address == mac_rx_pkg::OFS_CTL) ? ctl :
      (address == mac_rx_pkg::OFS_CFG) ? cfg :
      (address == mac_rx_pkg::OFS_RBQP) ? qptr :
      (address == mac_rx_pkg::OFS_RSR) ? rsr_word :
      (address == mac_rx_pkg::OFS_HASH_HI) ? hash_hi :
      (address == mac_rx_pkg::OFS_HASH_LO) ? hash_lo :
      sa_hit ? sa_word : 32'h0; // Unmapped reads give zero
   wire wr_rbqp = wr_fire && (address == mac_rx_pkg::OFS_RBQP);
   wire wr_rsr = wr_fire && (address == mac_rx_pkg::OFS_RSR);

   // One wait cycle per access; the answer is ready by the second edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0;
      end else begin
         waitrequest <= ~(req & waitrequest);
         if (read & waitrequest) begin
            readdata <= rd_mux;
         end
      end
   end

   // Control, hash and queue base registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= mac_rx_pkg::CTL_RST;
         cfg <= mac_rx_pkg::CFG_RST;
         rbqp <= mac_rx_pkg::RBQP_RST;
         hash_hi <= 32'h0;
         hash_lo <= 32'h0;
      end else if (wr_fire) begin
         if (address == mac_rx_pkg::OFS_CTL) begin
            ctl <= be_merge(ctl, writedata, byteenable) & mac_rx_pkg::CTL_MASK;
         end
         if (address == mac_rx_pkg::OFS_CFG) begin
            cfg <= be_merge(cfg, writedata, byteenable) & mac_rx_pkg::CFG_MASK;
         end
         if (wr_rbqp) begin
            rbqp <= be_merge(rbqp, writedata, byteenable) & mac_rx_pkg::RBQP_MASK;
         end
         if (address == mac_rx_pkg::OFS_HASH_HI) begin
            hash_hi <= be_merge(hash_hi, writedata, byteenable);
         end
         if (address == mac_rx_pkg::OFS_HASH_LO) begin
            hash_lo <= be_merge(hash_lo, writedata, byteenable);
         end
      end
   end

   // Specific addresses: byte lane 3 of the first word is the first wire byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            sa_lo[i] <= 32'h0;
            sa_hi[i] <= 16'h0;
         end
         sa_act <= 4'h0;
      end else if (wr_fire && sa_hit) begin
         if (!sa_hi_sel) begin
            sa_lo[sa_idx] <= be_merge(sa_lo[sa_idx], writedata, byteenable);
            if (byteenable[3]) begin
               sa_act[sa_idx] <= 1'b0;
            end
         end else begin
            sa_hi[sa_idx] <= sa_hi_new[15:0];
            if (byteenable[0]) begin
               sa_act[sa_idx] <= 1'b1;
            end
         end
      end
   end

   // Buffer-unavailable flag; a new event wins over a clear in the same cycle
   wire bna_set = (state == mac_rx_pkg::st_fetch) && !dma_waitrequest
                  && dma_readdata[mac_rx_pkg::W0_OWN];
   wire bna_clr = wr_rsr && byteenable[0] && writedata[mac_rx_pkg::RSR_BNA];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsr_bna <= 1'b0;
      end else begin
         rsr_bna <= bna_set | (rsr_bna & ~bna_clr);
      end
   end

   // Two-stage synchronisers for the PHY pins; rx_clk gets a third for edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxc_s <= 3'h0;
         rxd_s1 <= 4'h0;
         rxd_s2 <= 4'h0;
         dv_s1 <= 1'b0;
         dv_s2 <= 1'b0;
         er_s1 <= 1'b0;
         er_s2 <= 1'b0;
      end else begin
         rxc_s <= {rxc_s[1:0], rx_clk};
         rxd_s1 <= rxd;
         rxd_s2 <= rxd_s1;
         dv_s1 <= rx_dv;
         dv_s2 <= dv_s1;
         er_s1 <= rx_er;
         er_s2 <= er_s1;
      end
   end

   // Nibble stream events at each rising link edge; frame end needs no edge
   wire rx_rise = rxc_s[1] & ~rxc_s[2];
   wire dv_start = rx_rise & dv_s2 & ~dv_d;
   wire sfd_seen = rx_rise & dv_s2 & ~in_frame & (rxd_s2 == mac_rx_pkg::SFD_NIBBLE);
   wire byte_valid = rx_rise & dv_s2 & in_frame & nib_hi;
   wire frame_end = ~dv_s2 & in_frame; // No link edge needed: the PHY clock may stop
   wire [7:0] rx_byte = {rxd_s2, low_nib}; // Low nibble arrives first

   // Byte assembly; the first wire byte ends up in da[47:40]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dv_d <= 1'b0;
         in_frame <= 1'b0;
         nib_hi <= 1'b0;
         low_nib <= 4'h0;
         byte_cnt <= 11'h0;
         err_seen <= 1'b0;
         da <= 48'h0;
         crc <= mac_rx_pkg::CRC_INIT;
         da_done <= 1'b0;
      end else begin
         da_done <= byte_valid && (byte_cnt == mac_rx_pkg::DA_LAST_BYTE);
         if (rx_rise || !dv_s2) begin
            dv_d <= dv_s2; // Cleared without an edge so the next frame still jams
         end
         if (sfd_seen) begin
            in_frame <= 1'b1;
            nib_hi <= 1'b0;
            byte_cnt <= 11'h0;
            err_seen <= 1'b0;
            crc <= mac_rx_pkg::CRC_INIT;
         end else if (frame_end) begin
            in_frame <= 1'b0;
         end else if (rx_rise && dv_s2 && in_frame) begin
            nib_hi <= ~nib_hi;
            err_seen <= err_seen | er_s2;
            if (!nib_hi) begin
               low_nib <= rxd_s2;
            end else begin
               byte_cnt <= 11'(byte_cnt + 11'h1);
               if (byte_cnt <= mac_rx_pkg::DA_LAST_BYTE) begin
                  da <= {da[39:0], rx_byte};
                  crc <= crc_byte(crc, rx_byte);
               end
            end
         end
      end
   end

   // Address filter; only the destination field is looked at, never the source
   wire [63:0] hash_tab = {hash_hi, hash_lo};
   wire [5:0] hash_idx = crc[5:0];
   wire hash_bit = hash_tab[hash_idx];
   wire is_mc = da[40];
   wire [3:0] sa_m;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sa
         assign sa_m[g] = sa_act[g] && (da == {sa_lo[g], sa_hi[g]});
      end
   endgenerate
   wire bc_m = (da == mac_rx_pkg::BCAST_ADDR) & ~cfg[mac_rx_pkg::CFG_NBC];
   wire mh_m = is_mc & hash_bit & cfg[mac_rx_pkg::CFG_MTI];
   wire uh_m = ~is_mc & hash_bit & cfg[mac_rx_pkg::CFG_UNI];
   wire caf_m = cfg[mac_rx_pkg::CFG_CAF];
   wire blocked = tx_active & ~cfg[mac_rx_pkg::CFG_FD];
   wire any_m = (|sa_m) | bc_m | mh_m | uh_m | caf_m;
   wire accept = any_m & ~blocked & ctl[mac_rx_pkg::CTL_RE];

   // Decision is taken once, the cycle after the sixth address byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         store_frame <= 1'b0;
         local_match <= 1'b0;
         stored <= 1'b0;
         bc_f <= 1'b0;
         mh_f <= 1'b0;
         uh_f <= 1'b0;
         sa_f <= 4'h0;
      end else begin
         store_frame <= da_done & accept;
         local_match <= da_done & (|sa_m) & ~blocked;
         if (sfd_seen) begin
            stored <= 1'b0;
         end else if (da_done) begin
            stored <= accept && (state == mac_rx_pkg::st_recv);
            bc_f <= bc_m;
            mh_f <= mh_m;
            uh_f <= uh_m;
            sa_f <= sa_m;
         end
      end
   end

   // Status word: causes, reserved zeros, length including FCS
   wire [31:0] word1 = {bc_f, mh_f, uh_f, 1'b0, 1'b0, sa_f, 12'h0, byte_cnt};
   wire [31:0] word0_done = w0 | (32'h1 << mac_rx_pkg::W0_OWN);
   wire wrap_now = w0[mac_rx_pkg::W0_WRAP] || (qcnt == mac_rx_pkg::QUEUE_LAST);

   // Descriptor manager; a frame ending during the fetch is not recorded
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= mac_rx_pkg::st_idle;
         dma_address <= 32'h0;
         dma_read <= 1'b0;
         dma_write <= 1'b0;
         dma_writedata <= 32'h0;
         w0 <= 32'h0;
         qcnt <= 10'h0;
      end else begin
         case (state)
            mac_rx_pkg::st_idle: begin
               if (sfd_seen && ctl[mac_rx_pkg::CTL_RE]) begin
                  dma_address <= qptr;
                  dma_read <= 1'b1;
                  state <= mac_rx_pkg::st_fetch;
               end
            end
            mac_rx_pkg::st_fetch: begin
               if (!dma_waitrequest) begin
                  dma_read <= 1'b0;
                  w0 <= dma_readdata;
                  if (dma_readdata[mac_rx_pkg::W0_OWN]) begin
                     state <= mac_rx_pkg::st_drop;
                  end else begin
                     state <= mac_rx_pkg::st_recv;
                  end
               end
            end
            mac_rx_pkg::st_recv: begin
               if (frame_end) begin
                  if (stored && !err_seen) begin
                     dma_address <= qptr;
                     dma_writedata <= word0_done;
                     dma_write <= 1'b1;
                     state <= mac_rx_pkg::st_wr0;
                  end else begin
                     state <= mac_rx_pkg::st_idle; // Buffer recovered
                  end
               end
            end
            mac_rx_pkg::st_wr0: begin
               if (!dma_waitrequest) begin
                  dma_address <= 32'(qptr + {24'h0, mac_rx_pkg::OFS_ENTRY_W1});
                  dma_writedata <= word1;
                  state <= mac_rx_pkg::st_wr1;
               end
            end
            mac_rx_pkg::st_wr1: begin
               if (!dma_waitrequest) begin
                  dma_write <= 1'b0;
                  qcnt <= wrap_now ? 10'h0 : 10'(qcnt + 10'h1);
                  state <= mac_rx_pkg::st_idle;
               end
            end
            mac_rx_pkg::st_drop: begin
               if (frame_end) begin
                  state <= mac_rx_pkg::st_idle; // Entry reread on the next frame
               end
            end
            default: begin
               state <= mac_rx_pkg::st_idle;
            end
         endcase
         if (wr_rbqp) begin
            qcnt <= 10'h0; // New base restarts the queue
         end
      end
   end

   // Back-pressure jam, one nibble per link clock; lasts 16 link periods
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         jam_tx_en <= 1'b0;
         jam_txd <= 4'h0;
         jam_cnt <= 5'h0;
      end else if (!jam_tx_en) begin
         if (dv_start && ctl[mac_rx_pkg::CTL_BP] && !cfg[mac_rx_pkg::CFG_FD]) begin
            jam_tx_en <= 1'b1;
            jam_txd <= mac_rx_pkg::JAM_PATTERN[3:0];
            jam_cnt <= 5'h1;
         end
      end else if (!dv_s2) begin
         jam_tx_en <= 1'b0; // Link clock may stop once the frame is gone
         jam_txd <= 4'h0;
      end else if (rx_rise) begin
         if (jam_cnt == mac_rx_pkg::JAM_NIBBLES) begin
            jam_tx_en <= 1'b0;
            jam_txd <= 4'h0;
         end else begin
            jam_txd <= mac_rx_pkg::JAM_PATTERN[{jam_cnt[3:0], 2'b00} +: 4];
            jam_cnt <= 5'(jam_cnt + 5'h1);
         end
      end
   end

   // Checks on the block's own behaviour
   property p_jam_cause;
      @(posedge clk) disable iff (!rst_n)
      $rose(jam_tx_en) |-> $past(ctl[mac_rx_pkg::CTL_BP]) && !$past(cfg[mac_rx_pkg::CFG_FD]);
   endproperty
   a_jam_cause: assert property (p_jam_cause) else $error("jam without backpressure");

   property p_jam_len;
      @(posedge clk) disable iff (!rst_n)
      jam_tx_en |-> jam_cnt <= mac_rx_pkg::JAM_NIBBLES;
   endproperty
   a_jam_len: assert property (p_jam_len) else $error("jam longer than 64 bits");

   property p_rbqp_read;
      @(posedge clk) disable iff (!rst_n)
      (read && waitrequest && address == mac_rx_pkg::OFS_RBQP) |=> readdata == $past(qptr);
   endproperty
   a_rbqp_read: assert property (p_rbqp_read) else $error("queue pointer read wrong");

   property p_wrap;
      @(posedge clk) disable iff (!rst_n)
      (state == mac_rx_pkg::st_wr1 && !dma_waitrequest && !wr_rbqp && wrap_now) |=> qcnt == 0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("queue did not wrap");

   property p_bna;
      @(posedge clk) disable iff (!rst_n)
      bna_set |=> rsr_bna && state == mac_rx_pkg::st_drop;
   endproperty
   a_bna: assert property (p_bna) else $error("owned entry not refused");

   property p_w0_own;
      @(posedge clk) disable iff (!rst_n)
      (state == mac_rx_pkg::st_wr0 && dma_write && !dma_waitrequest) |->
         dma_writedata[mac_rx_pkg::W0_OWN] ##1 dma_address == $past(dma_address) + 32'h4;
   endproperty
   a_w0_own: assert property (p_w0_own) else $error("word 0 update wrong");

   property p_w1_resv;
      @(posedge clk) disable iff (!rst_n)
      state == mac_rx_pkg::st_wr1 |-> dma_writedata[22:11] == 12'h0
         && dma_writedata[28:27] == 2'h0;
   endproperty
   a_w1_resv: assert property (p_w1_resv) else $error("reserved status bits set");

   property p_half_block;
      @(posedge clk) disable iff (!rst_n)
      (da_done && blocked) |=> !store_frame;
   endproperty
   a_half_block: assert property (p_half_block) else $error("stored while transmitting");

   property p_bcast;
      @(posedge clk) disable iff (!rst_n)
      (da_done && da == mac_rx_pkg::BCAST_ADDR && !cfg[mac_rx_pkg::CFG_NBC] && !blocked
       && ctl[mac_rx_pkg::CTL_RE]) |=> store_frame;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast not stored");

   property p_caf;
      @(posedge clk) disable iff (!rst_n)
      (da_done && caf_m && !blocked && ctl[mac_rx_pkg::CTL_RE]) |=> store_frame;
   endproperty
   a_caf: assert property (p_caf) else $error("copy-all not stored");

   property p_sa_deact;
      @(posedge clk) disable iff (!rst_n)
      (wr_fire && sa_hit && !sa_hi_sel && byteenable[3]) |=> !sa_act[$past(sa_idx)];
   endproperty
   a_sa_deact: assert property (p_sa_deact) else $error("address not deactivated");

   c_frame_written: cover property (@(posedge clk) disable iff (!rst_n)
      state == mac_rx_pkg::st_wr1 && !dma_waitrequest);
   c_bna: cover property (@(posedge clk) disable iff (!rst_n) bna_set);
   c_jam: cover property (@(posedge clk) disable iff (!rst_n) $fell(jam_tx_en));
   c_local: cover property (@(posedge clk) disable iff (!rst_n) local_match);
endmodule : mac_rx_address_filter_descq

// ### rtl/mac_rx_pkg.sv
package mac_rx_pkg;
   // Register byte offsets on the slave bus; OFS_ENTRY_W1 is word 1 within a queue entry
   localparam logic [7:0] OFS_CTL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_RBQP = 8'h18;
   localparam logic [7:0] OFS_RSR = 8'h20;
   localparam logic [7:0] OFS_HASH_HI = 8'h90;
   localparam logic [7:0] OFS_HASH_LO = 8'h94;
   localparam logic [7:0] OFS_SA_BASE = 8'h98;
   localparam logic [7:0] OFS_SA_LAST = 8'hB4;
   localparam logic [7:0] OFS_ENTRY_W1 = 8'h04;

   // Implemented bits and reset values
   localparam logic [31:0] CTL_MASK = 32'h0000_01FF;
   localparam logic [31:0] CFG_MASK = 32'h0000_1FFF;
   localparam logic [31:0] CTL_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0800;
   localparam logic [31:0] RBQP_RST = 32'h0000_0000;
   localparam logic [31:0] RBQP_MASK = 32'hFFFF_FFFC;

   // Field positions
   localparam int CTL_RE = 2;
   localparam int CTL_BP = 8;
   localparam int CFG_FD = 1;
   localparam int CFG_CAF = 4;
   localparam int CFG_NBC = 5;
   localparam int CFG_MTI = 6;
   localparam int CFG_UNI = 7;
   localparam int RSR_BNA = 0;
   localparam int W0_OWN = 0;
   localparam int W0_WRAP = 1;

   // Descriptor queue geometry
   localparam int QCNT_W = 10;
   localparam logic [9:0] QUEUE_LAST = 10'h3FF;
   localparam int LEN_W = 11;

   // Frame framing and filtering constants
   localparam logic [3:0] SFD_NIBBLE = 4'hD;
   localparam logic [10:0] DA_LAST_BYTE = 11'h005;
   localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

   // Back-pressure jam: 64 bits sent as nibbles
   localparam int JAM_BITS = 64;
   localparam logic [4:0] JAM_NIBBLES = 5'(JAM_BITS / 4);
   localparam logic [63:0] JAM_PATTERN = 64'h5555_5555_5555_5555;

   typedef enum logic [2:0] {
      st_idle,
      st_fetch,
      st_recv,
      st_wr0,
      st_wr1,
      st_drop
   } desc_state_e;
endpackage : mac_rx_pkg

// ### tb/mac_rx_address_filter_descq_bench.sv
module mac_rx_address_filter_descq_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
   logic [7:0] address = 8'h00;
   logic [31:0] writedata = 32'h0000_0000, q;
   logic [3:0] byteenable = 4'hF, rxd = 4'h0;
   logic rx_clk = 1'b0, rx_dv = 1'b0, rx_er = 1'b0, tx_active = 1'b0;
   logic [31:0] readdata, dma_address, dma_writedata, dma_readdata;
   logic waitrequest, jam_tx_en, dma_read, dma_write, dma_waitrequest;
   logic store_frame, local_match;
   logic [3:0] jam_txd;
   int n_fail = 0, n_compared = 0, n_st = 0, n_lm = 0, n_jam = 0, n_jbad = 0;
   localparam logic [47:0] DA_A = 48'h0210_2030_4050;
   mac_rx_address_filter_descq dut (.clk(clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .rx_clk(rx_clk), .rxd(rxd),
      .rx_dv(rx_dv), .rx_er(rx_er), .tx_active(tx_active), .jam_tx_en(jam_tx_en),
      .jam_txd(jam_txd), .dma_address(dma_address), .dma_read(dma_read),
      .dma_write(dma_write), .dma_writedata(dma_writedata),
      .dma_readdata(dma_readdata), .dma_waitrequest(dma_waitrequest),
      .store_frame(store_frame), .local_match(local_match));
   mac_rx_mem_model mem (.clk(clk), .rst_n(rst_n), .dma_address(dma_address),
      .dma_read(dma_read), .dma_write(dma_write), .dma_writedata(dma_writedata),
      .dma_readdata(dma_readdata), .dma_waitrequest(dma_waitrequest));
   // System clock
   initial begin
      forever #50 clk = ~clk;
   end
   // Count filter pulses, each stands one cycle, and cycles with the jam enabled
   always @(posedge clk) begin
      if (store_frame === 1'b1) n_st++;
      if (local_match === 1'b1) n_lm++;
      if (jam_tx_en === 1'b1) n_jam++;
      if (jam_tx_en === 1'b1 && jam_txd !== mac_rx_pkg::JAM_PATTERN[3:0]) n_jbad++;
   end
   task automatic summarize();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Avalon access held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      if (i == 20) begin
         n_fail++;
         summarize();
      end
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   // Nibbles low first; link clock only runs inside the frame
   task automatic frame(input logic [47:0] da);
      int i;
      logic [3:0] nb [$];
      for (i = 0; i < 15; i++) nb.push_back(4'h5);
      nb.push_back(4'hD);
      for (i = 5; i >= 0; i--) begin
         nb.push_back(da[i*8+:4]);
         nb.push_back(da[i*8+4+:4]);
      end
      for (i = 0; i < 4; i++) nb.push_back(4'h0);
      foreach (nb[k]) begin
         @(posedge clk);
         rxd <= nb[k];
         rx_dv <= 1'b1;
         rx_clk <= 1'b0;
         repeat (4) @(posedge clk);
         rx_clk <= 1'b1;
         repeat (3) @(posedge clk);
      end
      @(posedge clk);
      rx_clk <= 1'b0;
      rx_dv <= 1'b0;
      rxd <= ~rxd;
      repeat (10) @(posedge clk);
   endtask : frame
   task automatic wait_wr(input int n);
      int i;
      for (i = 0; i < 400 && mem.n_wr < n; i++) @(posedge clk);
      if (i == 400) begin
         n_fail++;
         summarize();
      end
   endtask : wait_wr
   task automatic t_regs();
      bus(1'b0, mac_rx_pkg::OFS_CFG, 32'h0);
      chk("cfg reset", mac_rx_pkg::CFG_RST, q);
      bus(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h0000_0000, q);
      bus(1'b1, mac_rx_pkg::OFS_HASH_LO, 32'h1234_5678);
      bus(1'b0, mac_rx_pkg::OFS_HASH_LO, 32'h0);
      chk("hash low", 32'h1234_5678, q);
   endtask : t_regs
   // Specific address match stores frame with length and cause
   task automatic t_specific();
      bus(1'b1, mac_rx_pkg::OFS_RBQP, 32'h0);
      bus(1'b1, mac_rx_pkg::OFS_SA_BASE, 32'h0210_2030);
      bus(1'b1, mac_rx_pkg::OFS_SA_BASE + 8'h04, 32'h0000_4050);
      bus(1'b1, mac_rx_pkg::OFS_CTL, 32'h0000_0004);
      frame(DA_A);
      wait_wr(2);
      chk("stores", 32'(1), 32'(n_st));
      chk("local", 32'(1), 32'(n_lm));
      chk("word0", 32'h0000_0103, mem.m[0]);
      chk("word1", 32'h0080_0008, mem.m[1]);
      bus(1'b0, mac_rx_pkg::OFS_RBQP, 32'h0);
      chk("qptr", 32'h0000_0000, q);
   endtask : t_specific
   // Entry still owned by software
   task automatic t_owned();
      frame(DA_A);
      bus(1'b0, mac_rx_pkg::OFS_RSR, 32'h0);
      chk("unavail", 32'h0000_0001, q & 32'h1);
      chk("no write", 32'(2), 32'(mem.n_wr));
      bus(1'b1, mac_rx_pkg::OFS_RSR, 32'h0000_0001);
      mem.m[0] = 32'h0000_0102;
   endtask : t_owned
   task automatic t_bcast();
      frame(48'hFFFF_FFFF_FFFF);
      wait_wr(4);
      chk("bcast word1", 32'h8000_0008, mem.m[1]);
   endtask : t_bcast
   // Transmitting in half duplex blocks storing
   task automatic t_txblock();
      mem.m[0] = 32'h0000_0102;
      tx_active <= 1'b1;
      frame(DA_A);
      tx_active <= 1'b0;
      repeat (20) @(posedge clk);
      chk("blocked", 32'(4), 32'(mem.n_wr));
      chk("no pulse", 32'(3), 32'(n_st));
   endtask : t_txblock
   // Copy-all stores an unknown address; backpressure jams 64 bits meanwhile
   task automatic t_caf_jam();
      bus(1'b1, mac_rx_pkg::OFS_CFG, mac_rx_pkg::CFG_RST | 32'h0000_0010);
      bus(1'b1, mac_rx_pkg::OFS_CTL, 32'h0000_0104);
      n_jam = 0;
      frame(48'h0A0B_0C0D_0E0F);
      wait_wr(6);
      chk("caf word1", 32'h0000_0008, mem.m[1]);
      chk("caf pulse", 32'(4), 32'(n_st));
      chk("jam cycles", 32'(mac_rx_pkg::JAM_BITS / 4 * 8), 32'(n_jam));
      chk("jam data", 32'(0), 32'(n_jbad));
   endtask : t_caf_jam
   // All hash bits set admit any multicast destination
   task automatic t_mhash();
      mem.m[0] = 32'h0000_0102;
      bus(1'b1, mac_rx_pkg::OFS_CFG, mac_rx_pkg::CFG_RST | 32'h0000_0040);
      bus(1'b1, mac_rx_pkg::OFS_HASH_HI, 32'hFFFF_FFFF);
      bus(1'b1, mac_rx_pkg::OFS_HASH_LO, 32'hFFFF_FFFF);
      frame(48'h0300_0000_0001);
      wait_wr(8);
      chk("mhash word1", 32'h4000_0008, mem.m[1]);
      chk("mhash pulse", 32'(5), 32'(n_st));
   endtask : t_mhash
   initial begin
      mem.m[0] = 32'h0000_0102;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_specific();
      t_owned();
      t_bcast();
      t_txblock();
      t_caf_jam();
      t_mhash();
      summarize();
   end
endmodule : mac_rx_address_filter_descq_bench

// ### tb/mac_rx_mem_model.sv
// Memory slave answering descriptor accesses after one wait cycle
module mac_rx_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [31:0] dma_address,
   input wire logic dma_read,
   input wire logic dma_write,
   input wire logic [31:0] dma_writedata,
   output logic [31:0] dma_readdata,
   output logic dma_waitrequest
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] m [16];
   int n_wr = 0;
   wire logic [3:0] idx = dma_address[5:2];
   // Word 0 carries buffer address and owner flag as software leaves it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_waitrequest <= 1'b1;
         dma_readdata <= 32'h0000_0000;
      end else if (dma_waitrequest && (dma_read || dma_write)) begin
         dma_waitrequest <= 1'b0;
         dma_readdata <= m[idx];
      end else begin
         // Write lands only at the accepting edge
         if (!dma_waitrequest && dma_write) begin
            m[idx] <= dma_writedata;
            n_wr++;
         end
         dma_waitrequest <= 1'b1;
         dma_readdata <= ~dma_readdata; // Released bus inverts its data each cycle, so stale data returns every other cycle
      end
   end
endmodule : mac_rx_mem_model
